/* design/pfb_pkg.sv */
// Shared constants and types for the program flow branch unit
package pfb_pkg;

  localparam int PC_W = 22;

  // Operation selector presented with a request
  typedef enum logic [4:0] {
    OP_RELATIVE_JUMP = 5'h00,
    OP_INDIRECT_JUMP = 5'h01,
    OP_EXT_INDIRECT_JUMP = 5'h02,
    OP_DIRECT_JUMP = 5'h03,
    OP_REL_INVOKE = 5'h04,
    OP_IND_INVOKE = 5'h05,
    OP_EXT_IND_INVOKE = 5'h06,
    OP_ABS_INVOKE = 5'h07,
    OP_SUBROUTINE_EXIT = 5'h08,
    OP_INTERRUPT_EXIT = 5'h09,
    OP_COMPARE_SKIP_EQ = 5'h0a,
    OP_REGISTER_COMPARE = 5'h0b,
    OP_COMPARE_CARRY = 5'h0c,
    OP_COMPARE_IMM = 5'h0d,
    OP_SKIP_REG_CLEAR = 5'h0e,
    OP_SKIP_REG_SET = 5'h0f,
    OP_SKIP_IO_CLEAR = 5'h10,
    OP_SKIP_IO_SET = 5'h11,
    OP_BRANCH_FLAG_SET = 5'h12,
    OP_BRANCH_FLAG_CLEAR = 5'h13,
    OP_BRANCH_IF_EQUAL = 5'h14
  } pfb_op_e;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_BUSY = 1'b1
  } pfb_state_e;

  // Status flag bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_I = 7;

  // Cycle counts per instruction class
  localparam logic [2:0] CYC_ONE = 3'h1;
  localparam logic [2:0] CYC_TWO = 3'h2;
  localparam logic [2:0] CYC_THREE = 3'h3;
  localparam logic [2:0] CYC_FOUR = 3'h4;
  localparam logic [2:0] CYC_FIVE = 3'h5;

  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [PC_W-1:0] PC_RESET = 22'h00_0000;

endpackage

/* design/pfb_program_flow_branch_unit.sv */
// Program flow execution: jumps, invokes, exits, compares, skips and branches
//
// Function
// - Indirect jump loads pointer pair into counter, flags kept, two cycles.
// - Extended indirect jump loads high byte and pointer pair, two cycles.
// - Indirect invoke pushes return address, loads pointer pair, four cycles.
// - Extended indirect invoke pushes, loads high byte with pointer, four cycles.
// - Compare-skip-if-equal skips next one or two words when equal; 1/2/3 cycles.
// - Compares subtract unstored, set Z N V C H in one cycle; carry variant.
// - Skip when selected register bit is clear; 1/2/3 cycles, no flags.
// - Skip when selected register bit is set, counter plus 2 or 3.
// - Skip when selected I/O bit is clear; 1/2/3 cycles, no flags.
// - Skip when selected I/O bit is set; flags unchanged.
// - Branch adds offset plus one when chosen flag set; 1/2 cycles.
// - Branch adds offset plus one when chosen flag clear; else falls through.
// - Branch if equal takes relative branch only when zero flag set.
`timescale 1ns/100ps

module pfb_program_flow_branch_unit
  import pfb_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input wire pfb_op_e op,
  input wire logic [PC_W-1:0] pc_in,
  input wire logic [7:0] flags_in,
  input wire logic [11:0] offset,
  input wire logic [PC_W-1:0] target,
  input wire logic [15:0] pointer_pair,
  input wire logic [7:0] ext_high_byte,
  input wire logic [7:0] reg_d,
  input wire logic [7:0] reg_r,
  input wire logic [7:0] io_value,
  input wire logic [2:0] bit_sel,
  input wire logic next_is_two_word,
  input wire logic [PC_W-1:0] stack_pc,
  output logic busy,
  output logic done,
  output logic [PC_W-1:0] pc_out,
  output logic [7:0] flags_out,
  output logic push_pc,
  output logic [PC_W-1:0] push_value,
  output logic pop_pc
);

  typedef struct packed {
    pfb_state_e state;
    logic [2:0] remain;
    logic [PC_W-1:0] pc;
    logic [7:0] flags;
    logic done;
    logic push;
    logic [PC_W-1:0] push_value;
    logic pop;
  } pfb_state_s;

  pfb_state_s cur;
  pfb_state_s next_cur;

  logic [PC_W-1:0] pc_inc;
  logic [PC_W-1:0] pc_rel;
  logic [PC_W-1:0] pc_skip;
  logic [PC_W-1:0] pc_ext;
  logic [8:0] diff;
  logic [4:0] half_diff;
  logic borrow_in;
  logic [7:0] subtrahend;
  logic reg_bit;
  logic io_bit;
  logic flag_bit;
  logic skip_hit;
  logic branch_hit;

  assign pc_inc = pc_in + PC_W'(1);
  assign pc_rel = pc_in + PC_W'(signed'(offset)) + PC_W'(1);
  // Skipped instruction may be one or two words long
  assign pc_skip = pc_in + (next_is_two_word ? PC_W'(3) : PC_W'(2));
  assign pc_ext = PC_W'({ext_high_byte, pointer_pair});
  assign reg_bit = reg_r[bit_sel];
  assign io_bit = io_value[bit_sel];
  assign flag_bit = flags_in[bit_sel];
  // Immediate operand arrives on reg_r as well
  assign subtrahend = reg_r;
  assign borrow_in = (op == OP_COMPARE_CARRY) ? flags_in[FLAG_C] : 1'b0;
  assign diff = {1'b0, reg_d} - {1'b0, subtrahend} - {8'h00, borrow_in};
  assign half_diff = {1'b0, reg_d[3:0]} - {1'b0, subtrahend[3:0]} - {4'h0, borrow_in};

  // Condition tested by the skip and branch families
  always_comb
  begin
    skip_hit = 1'b0;
    branch_hit = 1'b0;
    case (op)
      OP_COMPARE_SKIP_EQ:
      begin
        skip_hit = (reg_d == reg_r);
      end
      OP_SKIP_REG_CLEAR:
      begin
        skip_hit = ~reg_bit;
      end
      OP_SKIP_REG_SET:
      begin
        skip_hit = reg_bit;
      end
      OP_SKIP_IO_CLEAR:
      begin
        skip_hit = ~io_bit;
      end
      OP_SKIP_IO_SET:
      begin
        skip_hit = io_bit;
      end
      OP_BRANCH_FLAG_SET:
      begin
        branch_hit = flag_bit;
      end
      OP_BRANCH_FLAG_CLEAR:
      begin
        branch_hit = ~flag_bit;
      end
      OP_BRANCH_IF_EQUAL:
      begin
        branch_hit = flags_in[FLAG_Z];
      end
      default:
      begin
        skip_hit = 1'b0;
      end
    endcase
  end

  always_comb
  begin
    logic [2:0] cycles;
    logic zero;
    logic ovf;
    cycles = CYC_ONE;
    zero = 1'b0;
    ovf = 1'b0;
    next_cur = cur;
    next_cur.done = 1'b0;
    next_cur.push = 1'b0;
    next_cur.pop = 1'b0;
    case (cur.state)
      ST_IDLE:
      begin
        if (start)
        begin
          next_cur.pc = pc_inc;
          next_cur.flags = flags_in;
          case (op)
            OP_RELATIVE_JUMP:
            begin
              next_cur.pc = pc_rel;
              cycles = CYC_TWO;
            end
            OP_INDIRECT_JUMP:
            begin
              next_cur.pc = PC_W'(pointer_pair);
              cycles = CYC_TWO;
            end
            OP_EXT_INDIRECT_JUMP:
            begin
              next_cur.pc = pc_ext;
              cycles = CYC_TWO;
            end
            OP_DIRECT_JUMP:
            begin
              next_cur.pc = target;
              cycles = CYC_THREE;
            end
            OP_REL_INVOKE:
            begin
              next_cur.pc = pc_rel;
              next_cur.push = 1'b1;
              next_cur.push_value = pc_inc;
              cycles = CYC_FOUR;
            end
            OP_IND_INVOKE:
            begin
              next_cur.pc = PC_W'(pointer_pair);
              next_cur.push = 1'b1;
              next_cur.push_value = pc_inc;
              cycles = CYC_FOUR;
            end
            OP_EXT_IND_INVOKE:
            begin
              next_cur.pc = pc_ext;
              next_cur.push = 1'b1;
              next_cur.push_value = pc_inc;
              cycles = CYC_FOUR;
            end
            OP_ABS_INVOKE:
            begin
              // Return address follows the two-word instruction
              next_cur.pc = target;
              next_cur.push = 1'b1;
              next_cur.push_value = pc_in + PC_W'(2);
              cycles = CYC_FIVE;
            end
            OP_SUBROUTINE_EXIT, OP_INTERRUPT_EXIT:
            begin
              next_cur.pc = stack_pc;
              next_cur.pop = 1'b1;
              cycles = CYC_FIVE;
              if (op == OP_INTERRUPT_EXIT)
              begin
                next_cur.flags[FLAG_I] = 1'b1;
              end
            end
            OP_REGISTER_COMPARE, OP_COMPARE_CARRY, OP_COMPARE_IMM:
            begin
              zero = (diff[7:0] == 8'h00);
              ovf = (reg_d[7] ^ subtrahend[7]) & (reg_d[7] ^ diff[7]);
              // Carry variant keeps Z only when the earlier byte was zero too
              next_cur.flags[FLAG_Z] = (op == OP_COMPARE_CARRY) ?
                (zero & flags_in[FLAG_Z]) : zero;
              next_cur.flags[FLAG_N] = diff[7];
              next_cur.flags[FLAG_V] = ovf;
              next_cur.flags[FLAG_S] = diff[7] ^ ovf;
              next_cur.flags[FLAG_C] = diff[8];
              next_cur.flags[FLAG_H] = half_diff[4];
            end
            OP_COMPARE_SKIP_EQ, OP_SKIP_REG_CLEAR, OP_SKIP_REG_SET,
            OP_SKIP_IO_CLEAR, OP_SKIP_IO_SET:
            begin
              // Cost grows with the length of the skipped instruction
              if (skip_hit)
              begin
                next_cur.pc = pc_skip;
                cycles = next_is_two_word ? CYC_THREE : CYC_TWO;
              end
            end
            OP_BRANCH_FLAG_SET, OP_BRANCH_FLAG_CLEAR, OP_BRANCH_IF_EQUAL:
            begin
              if (branch_hit)
              begin
                next_cur.pc = pc_rel;
                cycles = CYC_TWO;
              end
            end
            default:
            begin
              next_cur.pc = pc_inc;
            end
          endcase
          if (cycles == CYC_ONE)
          begin
            next_cur.done = 1'b1;
          end
          else
          begin
            next_cur.state = ST_BUSY;
            next_cur.remain = cycles - CYC_TWO;
          end
        end
      end
      ST_BUSY:
      begin
        // Multi-cycle instructions load the result at start and count down to done in the final cycle
        if (cur.remain == 3'h0)
        begin
          next_cur.state = ST_IDLE;
          next_cur.done = 1'b1;
        end
        else
        begin
          next_cur.remain = cur.remain - 3'h1;
        end
      end
      default:
      begin
        next_cur.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cur <= '{state: ST_IDLE, remain: 3'h0, pc: PC_RESET, flags: FLAGS_RESET,
               done: 1'b0, push: 1'b0, push_value: PC_RESET, pop: 1'b0};
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign busy = (cur.state == ST_BUSY);
  assign done = cur.done;
  assign pc_out = cur.pc;
  assign flags_out = cur.flags;
  assign push_pc = cur.push;
  assign push_value = cur.push_value;
  assign pop_pc = cur.pop;

endmodule // pfb_program_flow_branch_unit

/* bench/pfb_flow_properties.sv */
// Port-level assertions for the program flow branch unit
`timescale 1ns/100ps
module pfb_flow_chk
  import pfb_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input wire pfb_op_e op,
  input wire logic [PC_W-1:0] pc_in,
  input wire logic [7:0] flags_in,
  input wire logic [11:0] offset,
  input wire logic busy,
  input wire logic done,
  input wire logic [PC_W-1:0] pc_out,
  input wire logic [7:0] flags_out,
  input wire logic push_pc,
  input wire logic [PC_W-1:0] push_value,
  input wire logic pop_pc
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire go = start && !busy;
  property p_ij; go && op == OP_INDIRECT_JUMP |=> !done ##1 done; endproperty
  a_ij: assert property (p_ij) else $error("indirect jump timing");
  property p_ijf; go && op == OP_INDIRECT_JUMP |=> flags_out == $past(flags_in); endproperty
  a_ijf: assert property (p_ijf) else $error("indirect jump flags");
  property p_eic;
    go && op == OP_EXT_IND_INVOKE |=> push_pc && push_value == PC_W'($past(pc_in) + 1);
  endproperty
  a_eic: assert property (p_eic) else $error("return address push");
  property p_jmp; go && op == OP_DIRECT_JUMP |=> !done [*2] ##1 done; endproperty
  a_jmp: assert property (p_jmp) else $error("direct jump timing");
  property p_rj;
    go && op == OP_RELATIVE_JUMP
      |=> pc_out == PC_W'($past(pc_in) + PC_W'($signed($past(offset))) + 1);
  endproperty
  a_rj: assert property (p_rj) else $error("relative jump target");
  property p_ret; go && op == OP_SUBROUTINE_EXIT |=> pop_pc && !done ##1 !done [*3] ##1 done;
  endproperty
  a_ret: assert property (p_ret) else $error("exit timing");
  property p_rti; go && op == OP_INTERRUPT_EXIT |-> ##5 done && flags_out[FLAG_I]; endproperty
  a_rti: assert property (p_rti) else $error("interrupt exit flag");
  property p_cpi; go && op == OP_COMPARE_IMM |=> done && pc_out == PC_W'($past(pc_in) + 1);
  endproperty
  a_cpi: assert property (p_cpi) else $error("compare timing");
  property p_beq; go && op == OP_BRANCH_IF_EQUAL && flags_in[FLAG_Z] |=> !done ##1 done;
  endproperty
  a_beq: assert property (p_beq) else $error("taken branch timing");
endmodule // pfb_flow_chk

bind pfb_program_flow_branch_unit pfb_flow_chk u_chk (.clk, .reset, .start, .op, .pc_in,
  .flags_in, .offset, .busy, .done, .pc_out, .flags_out, .push_pc, .push_value, .pop_pc);

/* bench/pfb_program_flow_branch_unit_tb.sv */
// Randomised self-checking bench for the program flow branch unit
`timescale 1ns/100ps
module pfb_program_flow_branch_unit_tb
  import pfb_pkg::*;
;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic start = 1'b0;
  pfb_op_e op = OP_RELATIVE_JUMP;
  logic [PC_W-1:0] pc_in = '0, target = '0, stack_pc = '0, pc_out, push_value, ep, epv;
  logic [15:0] pointer_pair = '0;
  logic [11:0] offset = '0;
  logic [7:0] flags_in = '0, ext_high_byte = '0, reg_d = '0, reg_r = '0, io_value = '0;
  logic [7:0] flags_out, ef;
  logic [2:0] bit_sel = '0;
  logic next_is_two_word = 1'b0;
  logic busy, done, push_pc, pop_pc, epush, epop;
  int n_errors = 0, comparisons = 0, cyc = 0, ec, seed = 37634;

  always #10 clk = ~clk;

  pfb_program_flow_branch_unit uut (.clk, .reset, .start, .op, .pc_in, .flags_in, .offset,
    .target, .pointer_pair, .ext_high_byte, .reg_d, .reg_r, .io_value, .bit_sel,
    .next_is_two_word, .stack_pc, .busy, .done, .pc_out, .flags_out, .push_pc, .push_value,
    .pop_pc);

  task automatic end_of_test();
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic void predict();
    logic [8:0] d;
    logic [4:0] h;
    logic c, v, hit;
    c = op == OP_COMPARE_CARRY && flags_in[FLAG_C];
    d = {1'b0, reg_d} - {1'b0, reg_r} - c;
    h = {1'b0, reg_d[3:0]} - {1'b0, reg_r[3:0]} - c;
    v = reg_d[7] != reg_r[7] && d[7] != reg_d[7];
    epv = PC_W'(pc_in + (op == OP_ABS_INVOKE ? 2 : 1));
    epush = op inside {OP_REL_INVOKE, OP_IND_INVOKE, OP_EXT_IND_INVOKE, OP_ABS_INVOKE};
    epop = op inside {OP_SUBROUTINE_EXIT, OP_INTERRUPT_EXIT};
    ef = flags_in;
    ef[FLAG_I] = flags_in[FLAG_I] | op == OP_INTERRUPT_EXIT;
    if (op inside {OP_REGISTER_COMPARE, OP_COMPARE_CARRY, OP_COMPARE_IMM})
      ef = {flags_in[7:6], h[4], d[7] ^ v, v, d[7],
        d[7:0] == 0 && (op != OP_COMPARE_CARRY || flags_in[FLAG_Z]), d[8]};
    case (op)
      OP_RELATIVE_JUMP, OP_REL_INVOKE: ep = PC_W'(pc_in + PC_W'($signed(offset)) + 1);
      OP_INDIRECT_JUMP, OP_IND_INVOKE: ep = PC_W'(pointer_pair);
      OP_EXT_INDIRECT_JUMP, OP_EXT_IND_INVOKE: ep = PC_W'({ext_high_byte, pointer_pair});
      OP_DIRECT_JUMP, OP_ABS_INVOKE: ep = target;
      OP_SUBROUTINE_EXIT, OP_INTERRUPT_EXIT: ep = stack_pc;
      default: ep = PC_W'(pc_in + 1);
    endcase
    case (op)
      OP_RELATIVE_JUMP, OP_INDIRECT_JUMP, OP_EXT_INDIRECT_JUMP: ec = 2;
      OP_DIRECT_JUMP: ec = 3;
      OP_REL_INVOKE, OP_IND_INVOKE, OP_EXT_IND_INVOKE: ec = 4;
      OP_ABS_INVOKE, OP_SUBROUTINE_EXIT, OP_INTERRUPT_EXIT: ec = 5;
      default: ec = 1;
    endcase
    case (op)
      OP_COMPARE_SKIP_EQ: hit = reg_d == reg_r;
      OP_SKIP_REG_CLEAR: hit = !reg_r[bit_sel];
      OP_SKIP_REG_SET: hit = reg_r[bit_sel];
      OP_SKIP_IO_CLEAR: hit = !io_value[bit_sel];
      OP_SKIP_IO_SET: hit = io_value[bit_sel];
      default: hit = 1'b0;
    endcase
    ep = hit ? PC_W'(pc_in + 2 + next_is_two_word) : ep;
    ec = hit ? 2 + next_is_two_word : ec;
    case (op)
      OP_BRANCH_FLAG_SET: hit = flags_in[bit_sel];
      OP_BRANCH_FLAG_CLEAR: hit = !flags_in[bit_sel];
      OP_BRANCH_IF_EQUAL: hit = flags_in[FLAG_Z];
      default: hit = 1'b0;
    endcase
    ep = hit ? PC_W'(pc_in + PC_W'($signed(offset)) + 1) : ep;
    ec = hit ? 2 : ec;
  endfunction

  // Corner mode forces the most negative offset and a two-word successor
  task automatic exec(input pfb_op_e o, input bit corner);
    logic [15:0] r;
    int n;
    @(posedge clk);
    r = 16'($random(seed));
    start <= 1'b1;
    op <= o;
    pc_in <= PC_W'($random(seed));
    flags_in <= 8'($random(seed));
    offset <= corner ? 12'h800 : 12'($random(seed));
    target <= PC_W'($random(seed));
    stack_pc <= PC_W'($random(seed));
    pointer_pair <= 16'($random(seed));
    ext_high_byte <= 8'($random(seed));
    reg_d <= r[7:0];
    reg_r <= r[8] ? r[7:0] : r[15:8];
    io_value <= 8'($random(seed));
    bit_sel <= 3'($random(seed));
    next_is_two_word <= corner | r[9];
    #1;
    predict();
    @(posedge clk);
    // Corner runs hold start into the busy cycle, where it must be ignored
    start <= corner && ec > 1;
    pc_in <= ~pc_in;
    #1;
    check("busy", ec > 1, busy);
    check("push_pc", epush, push_pc);
    if (epush)
      check("push_value", epv, push_value);
    check("pop_pc", epop, pop_pc);
    n = 1;
    while (done !== 1'b1 && n < 8)
    begin
      @(posedge clk);
      start <= 1'b0;
      #1;
      n++;
    end
    check("cycles", ec, n);
    check("pc_out", ep, pc_out);
    check("flags_out", ef, flags_out);
  endtask

  // Limit well above the expected run of about 1600 cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      n_errors++;
      end_of_test();
    end
  end

  initial
  begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 462; i++)
      exec(pfb_op_e'(i % 21), i < 21);
    end_of_test();
  end
endmodule // pfb_program_flow_branch_unit_tb
